// ### mxb_ctrl.sv
// Multiplexed external bus controller: register slave plus bus sequencer.
// Assumes synchronous Avalon-MM masters for registers and for the window.
// Notes on behaviour
// - Window hit asserts chip select, starts sequencer
// - 8-bit mode aliases device in both halves
// - 16-bit mode: all lines address and data
// - 8-bit mode: upper lines carry address while chip select is low
// - Address bits 15:0 or 16:1 by width
// - Wide requests split into several accesses
// - Pins change on bus clock edge
// - Divider codes select divide by 1 to 32
// - Chip select, one setup clock, then latch
// - Latch low, hold plus turnaround, then strobe
// - Strobe for access time, then hold time
// - Latch high equals field plus one
// - Access time 1 to 32 clocks
// - Hold time 1 to 8 clocks
// - Address during latch, then data or float
// - Controls inactive during idle cycles
// - Idle after writes and between reads of one split read
// - Width select and enable bits
// - Timing register field positions
// - Chip select high during idle cycles
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/100ps
module mxb_ctrl (
  input wire logic i_clk, // System clock, 100 MHz
  input wire logic i_arst_n, // Asynchronous reset, active low
  input wire logic [3:0] i_reg_address, // Register byte address
  input wire logic i_reg_read, // Register read request
  input wire logic i_reg_write, // Register write request
  input wire logic [31:0] i_reg_writedata, // Register write data
  input wire logic [3:0] i_reg_byteenable, // Register byte lanes
  output logic [31:0] o_reg_readdata, // Register read data
  output logic o_reg_waitrequest, // Register stall
  input wire logic [16:0] i_win_address, // Byte address in window
  input wire logic i_win_read, // Window read request
  input wire logic i_win_write, // Window write request
  input wire logic [31:0] i_win_writedata, // Window write data
  input wire logic [3:0] i_win_byteenable, // Window byte lanes
  output logic [31:0] o_win_readdata, // Window read data
  output logic o_win_waitrequest, // Window stall
  input wire logic [15:0] i_ad, // Shared lines, input side
  output logic [15:0] o_ad, // Shared lines, output side
  output logic [15:0] o_ad_oe, // Shared lines, drive enable
  output logic o_chip_select_n, // Chip select, active low
  output logic o_ale, // Address latch strobe
  output logic o_read_strobe_n, // Read strobe, active low
  output logic o_write_strobe_n // Write strobe, active low
);
  mxb_pkg::mxb_state_s st;
  mxb_pkg::mxb_state_s next_st;
  logic [1:0] rst_sync; // Reset release flops, own reset domain
  logic rst_n;

  // Divide ratio minus one for a divider code
  function automatic logic [4:0] div_limit(input logic [2:0] code);
    if (code > mxb_pkg::DIV_MAX_CODE) begin
      div_limit = 5'h00; // Default rate is divide by one
    end else begin
      div_limit = 5'((6'h01 << code) - 6'h01);
    end
  endfunction

  // Lowest enabled byte lane at or above a start lane
  function automatic logic [1:0] next_lane(input logic [3:0] be,
      input logic [1:0] from);
    logic [1:0] r;
    r = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (be[i] && (2'(i) >= from)) begin
        r = 2'(i);
      end
    end
    next_lane = r;
  endfunction

  // Address pattern on the shared lines for one lane or halfword
  function automatic logic [15:0] pin_addr(input logic [16:0] addr,
      input logic w16, input logic [1:0] lane);
    if (w16) begin
      // Halfword address, system bit 0 unused
      pin_addr = {addr[16:2], lane[1]};
    end else begin
      // Byte address; bit 16 dropped so both halves alias
      pin_addr = {addr[15:8], addr[7:2], lane};
    end
  endfunction

  // Reset release through two flip-flops
  // Asserts at once, releases two edges after the pin
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  // Only the second flop feeds the design
  assign rst_n = rst_sync[1];

  // Next state of everything but the reset synchroniser
  always_comb begin
    logic en;
    logic w16;
    logic hit_last;
    logic [4:0] lat;
    logic [4:0] acc;
    logic [4:0] hld;
    logic [4:0] idl;
    logic [1:0] lane;
    logic [31:0] wmask;
    en = 1'b0;
    w16 = 1'b0;
    hit_last = 1'b0;
    lat = 5'h00;
    acc = 5'h00;
    hld = 5'h00;
    idl = 5'h00;
    lane = 2'h0;
    wmask = 32'h0;
    next_st = st;
    en = st.gen_ctrl[mxb_pkg::BIT_ENABLE];
    w16 = st.gen_ctrl[mxb_pkg::BIT_WIDTH16];
    lat = {2'b00, st.gen_ctrl[mxb_pkg::POS_LATCH_EXT +: 3]};
    acc = st.timing[mxb_pkg::POS_ACC +: 5];
    hld = {2'b00, st.timing[mxb_pkg::POS_HOLD +: 3]};

    // Bus clock enable from the divider
    next_st.clk_en = 1'b0;
    if (st.div_cnt >= div_limit(st.gen_ctrl[mxb_pkg::POS_DIV +: 3])) begin
      next_st.div_cnt = 5'h00;
      next_st.clk_en = 1'b1;
    end else begin
      next_st.div_cnt = st.div_cnt + 5'h01;
    end

    // Register slave: one wait cycle, answer on the second
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{i_reg_byteenable[b]}};
    end
    // Answer flag blocks a second take of the same request
    next_st.reg_wait_n = 1'b0;
    if ((i_reg_read || i_reg_write) && !st.reg_wait_n) begin
      next_st.reg_wait_n = 1'b1;
      if (i_reg_address == mxb_pkg::OFS_GEN_CTRL) begin
        next_st.reg_rdata = st.gen_ctrl;
        if (i_reg_write) begin
          next_st.gen_ctrl = (st.gen_ctrl & ~(wmask & mxb_pkg::MASK_GEN_CTRL))
            | (i_reg_writedata & wmask & mxb_pkg::MASK_GEN_CTRL);
        end
      end else if (i_reg_address == mxb_pkg::OFS_TIMING) begin
        next_st.reg_rdata = st.timing;
        if (i_reg_write) begin
          next_st.timing = (st.timing & ~(wmask & mxb_pkg::MASK_TIMING))
            | (i_reg_writedata & wmask & mxb_pkg::MASK_TIMING);
        end
      end else begin
        next_st.reg_rdata = 32'h0; // Unmapped reads as zero
      end
    end

    // Window answer is a single-cycle acknowledge
    next_st.win_ack = 1'b0;
    lane = st.part;
    // Does the current part end the request?
    if (w16) begin
      hit_last = (st.part[1] == 1'b1) || !(|st.be[3:2]);
    end else begin
      // Last byte when no enabled lane lies above this one
      hit_last = ((st.be >> st.part) <= 4'h1);
    end

    // Bus sequencer, advanced only on bus clock enables
    if (!st.busy) begin
      if ((i_win_read || i_win_write) && !st.win_ack) begin
        if (!en) begin
          next_st.win_ack = 1'b1; // refused, answer with zero
          next_st.rdata = 32'h0;
        end else begin
          next_st.busy = 1'b1;
          next_st.addr = i_win_address;
          next_st.wdata = i_win_writedata;
          next_st.be = (i_win_byteenable == 4'h0) ? 4'hf : i_win_byteenable;
          next_st.is_write = i_win_write;
          next_st.rdata = 32'h0;
          next_st.phase = mxb_pkg::MXB_IDLE;
          next_st.part = 2'h0;
        end
      end
    end else if (st.clk_en) begin
      next_st.cnt = st.cnt + 5'h01;
      case (st.phase)
        mxb_pkg::MXB_IDLE: begin
          // Pick first lane or halfword of this request
          if (w16) begin
            next_st.part = (|st.be[1:0]) ? 2'h0 : 2'h2;
          end else begin
            next_st.part = next_lane(st.be, 2'h0);
          end
          next_st.phase = mxb_pkg::MXB_SETUP;
          next_st.cnt = 5'h00;
          next_st.pins.cs_n = 1'b0;
          // Address stands through the setup clock
          next_st.pins.ad_out = pin_addr(st.addr, w16, next_st.part);
          next_st.pins.ad_oe = 16'hffff;
        end
        mxb_pkg::MXB_SETUP: begin
          next_st.pins.ad_out = pin_addr(st.addr, w16, lane);
          next_st.pins.ad_oe = 16'hffff;
          if (st.cnt >= mxb_pkg::FIXED_PHASE) begin
            next_st.phase = mxb_pkg::MXB_LATCH;
            next_st.pins.ale = 1'b1;
            next_st.cnt = 5'h00;
          end
        end
        mxb_pkg::MXB_LATCH: begin
          if (st.cnt >= lat) begin
            next_st.phase = mxb_pkg::MXB_LHOLD;
            next_st.pins.ale = 1'b0;
            next_st.cnt = 5'h00;
          end
        end
        mxb_pkg::MXB_LHOLD: begin
          next_st.phase = mxb_pkg::MXB_TURN;
          next_st.cnt = 5'h00;
          // float or drive write data after the latch
          next_st.pins.ad_oe = w16 ? 16'h0000 : 16'hff00;
          if (st.is_write) begin
            next_st.pins.ad_oe = 16'hffff;
            if (w16) begin
              next_st.pins.ad_out = lane[1] ? st.wdata[31:16]
                : st.wdata[15:0];
            end else begin
              next_st.pins.ad_out[7:0] = st.wdata[lane*8 +: 8];
            end
          end
        end
        mxb_pkg::MXB_TURN: begin
          next_st.phase = mxb_pkg::MXB_STROBE;
          next_st.cnt = 5'h00;
          next_st.pins.rd_n = st.is_write;
          next_st.pins.wr_n = !st.is_write;
        end
        mxb_pkg::MXB_STROBE: begin
          if (st.cnt >= acc) begin
            next_st.phase = mxb_pkg::MXB_DHOLD;
            next_st.pins.rd_n = 1'b1;
            next_st.pins.wr_n = 1'b1;
            next_st.cnt = 5'h00;
            if (!st.is_write) begin
              if (w16) begin
                next_st.rdata[lane[1]*16 +: 16] = i_ad;
              end else begin
                next_st.rdata[lane*8 +: 8] = i_ad[7:0];
              end
            end
          end
        end
        mxb_pkg::MXB_DHOLD: begin
          if (st.cnt >= hld) begin
            next_st.pins.cs_n = 1'b1;
            next_st.pins.ad_oe = 16'h0000;
            next_st.cnt = 5'h00;
            next_st.phase = hit_last ? mxb_pkg::MXB_DONE : mxb_pkg::MXB_GAP;
            next_st.last_read = !st.is_write;
            if (!hit_last) begin
              next_st.part = w16 ? 2'h2 : next_lane(st.be, st.part + 2'h1);
            end
          end
        end
        mxb_pkg::MXB_GAP: begin
          // idle after writes, or between reads of a split read
          idl = st.is_write ? {1'b0, st.timing[mxb_pkg::POS_W_IDLE +: 4]}
            : {1'b0, st.timing[mxb_pkg::POS_RR_IDLE +: 4]};
          if (st.cnt >= idl) begin
            next_st.phase = mxb_pkg::MXB_SETUP;
            next_st.pins.cs_n = 1'b0;
            next_st.pins.ad_out = pin_addr(st.addr, w16, lane);
            next_st.pins.ad_oe = 16'hffff;
            next_st.cnt = 5'h00;
          end
        end
        mxb_pkg::MXB_DONE: begin
          // controls stay inactive through write idle
          idl = st.is_write ? {1'b0, st.timing[mxb_pkg::POS_W_IDLE +: 4]}
            : 5'h00;
          if (st.cnt >= idl) begin
            next_st.busy = 1'b0;
            next_st.win_ack = 1'b1;
            next_st.phase = mxb_pkg::MXB_IDLE;
          end
        end
        default: begin
          next_st.phase = mxb_pkg::MXB_IDLE;
        end
      endcase
    end

    // disabling mid-access forces the pins inactive
    if (!en) begin
      next_st.pins.cs_n = 1'b1;
      next_st.pins.ale = 1'b0;
      next_st.pins.rd_n = 1'b1;
      next_st.pins.wr_n = 1'b1;
      next_st.pins.ad_oe = 16'h0000;
      // An access in flight is cut short and answered
      if (st.busy) begin
        next_st.busy = 1'b0;
        next_st.win_ack = 1'b1;
        next_st.phase = mxb_pkg::MXB_IDLE;
      end
    end
  end

  // State register on the synchronised reset
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.gen_ctrl <= mxb_pkg::RST_GEN_CTRL;
      st.timing <= mxb_pkg::RST_TIMING;
      st.reg_rdata <= 32'h0;
      st.reg_wait_n <= 1'b0;
      st.phase <= mxb_pkg::MXB_IDLE;
      st.cnt <= 5'h00;
      st.div_cnt <= 5'h00;
      st.clk_en <= 1'b0;
      st.addr <= 17'h0;
      st.wdata <= 32'h0;
      st.rdata <= 32'h0;
      st.be <= 4'h0;
      st.is_write <= 1'b0;
      st.last_read <= 1'b0;
      st.part <= 2'h0;
      st.busy <= 1'b0;
      st.win_ack <= 1'b0;
      st.pins <= '{cs_n: 1'b1, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
        ad_out: 16'h0000, ad_oe: 16'h0000};
    end else begin
      st.gen_ctrl <= next_st.gen_ctrl;
      st.timing <= next_st.timing;
      st.reg_rdata <= next_st.reg_rdata;
      st.reg_wait_n <= next_st.reg_wait_n;
      st.phase <= next_st.phase;
      st.cnt <= next_st.cnt;
      st.div_cnt <= next_st.div_cnt;
      st.clk_en <= next_st.clk_en;
      st.addr <= next_st.addr;
      st.wdata <= next_st.wdata;
      st.rdata <= next_st.rdata;
      st.be <= next_st.be;
      st.is_write <= next_st.is_write;
      st.last_read <= next_st.last_read;
      st.part <= next_st.part;
      st.busy <= next_st.busy;
      st.win_ack <= next_st.win_ack;
      st.pins <= next_st.pins;
    end
  end

  // Outputs straight from flip-flops
  assign o_reg_readdata = st.reg_rdata;
  assign o_reg_waitrequest = !st.reg_wait_n;
  assign o_win_readdata = st.rdata;
  assign o_win_waitrequest = !st.win_ack;
  assign o_ad = st.pins.ad_out;
  assign o_ad_oe = st.pins.ad_oe;
  assign o_chip_select_n = st.pins.cs_n;
  assign o_ale = st.pins.ale;
  assign o_read_strobe_n = st.pins.rd_n;
  assign o_write_strobe_n = st.pins.wr_n;
endmodule // mxb_ctrl

// ### mxb_pkg.sv
// Package for the multiplexed external bus controller.
// Assumes one system clock; all external timing is derived from it.
package mxb_pkg;
  // Register offsets (byte addresses)
  localparam logic [3:0] OFS_GEN_CTRL = 4'h0;
  localparam logic [3:0] OFS_TIMING = 4'h4;
  localparam logic [31:0] RST_GEN_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_TIMING = 32'h0000_0000;
  // General control fields
  localparam int BIT_ENABLE = 0;
  localparam int BIT_WIDTH16 = 1;
  localparam int POS_DIV = 8;
  localparam int POS_LATCH_EXT = 16;
  // Timing fields
  localparam int POS_ACC = 3;
  localparam int POS_HOLD = 8;
  localparam int POS_W_IDLE = 12;
  localparam int POS_RR_IDLE = 24;
  // Writable bit masks
  localparam logic [31:0] MASK_GEN_CTRL = 32'h0007_0703;
  localparam logic [31:0] MASK_TIMING = 32'h0f00_f7f8;
  // Window: 128 KB, 17 address bits
  localparam int WIN_ABITS = 17;
  // Fixed one-clock phases
  localparam logic [4:0] FIXED_PHASE = 5'h00;
  // Divider codes above this select the default rate
  localparam logic [2:0] DIV_MAX_CODE = 3'h5;

  // Bus controller phases
  typedef enum logic [3:0] {
    MXB_IDLE, MXB_SETUP, MXB_LATCH, MXB_LHOLD, MXB_TURN,
    MXB_STROBE, MXB_DHOLD, MXB_GAP, MXB_DONE
  } mxb_phase_e;

  // External pin group
  typedef struct packed {
    logic cs_n;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [15:0] ad_out;
    logic [15:0] ad_oe;
  } mxb_pins_s;

  // Complete state of the controller
  typedef struct packed {
    logic [31:0] gen_ctrl;
    logic [31:0] timing;
    logic [31:0] reg_rdata;
    logic reg_wait_n;
    mxb_phase_e phase;
    logic [4:0] cnt;
    logic [4:0] div_cnt;
    logic clk_en;
    logic [16:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] be;
    logic is_write;
    logic last_read;
    logic [1:0] part;
    logic busy;
    logic win_ack;
    mxb_pins_s pins;
  } mxb_state_s;
endpackage

// ### mxb_ctrl_monitor.sv
// Checker for the pin sequencing of mxb_ctrl.
// Assumes it is bound to mxb_ctrl and sees its ports only.
`timescale 1ns/100ps
module mxb_ctrl_monitor (
  input wire logic i_clk, // System clock
  input wire logic i_arst_n, // Reset, active low
  input wire logic i_win_read, // Window read
  input wire logic i_win_write, // Window write
  input wire logic o_win_waitrequest, // Window stall
  input wire logic [15:0] o_ad_oe, // Line enables
  input wire logic o_chip_select_n, // Chip select
  input wire logic o_ale, // Latch strobe
  input wire logic o_read_strobe_n, // Read strobe
  input wire logic o_write_strobe_n // Write strobe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  logic strb; // Either strobe low
  assign strb = !o_read_strobe_n || !o_write_strobe_n;
  // Latch hold and turnaround with strobes quiet
  sequence s_quiet;
    !strb [*2];
  endsequence
  // Bounded wait for the window answer
  sequence s_answer;
    ##[1:1000] !o_win_waitrequest;
  endsequence
  a_idle_quiet: assert property (
    o_chip_select_n |-> !o_ale && !strb)
    else $error("control active while deselected");
  a_setup_first: assert property (
    $rose(o_ale) |-> !$past(o_chip_select_n))
    else $error("latch rose without setup clock");
  a_latch_gap: assert property (
    $fell(o_ale) |-> s_quiet)
    else $error("strobe too soon after latch");
  a_latch_alone: assert property (
    o_ale |-> !strb)
    else $error("latch and strobe together");
  a_addr_driven: assert property (
    o_ale |-> o_ad_oe == 16'hffff)
    else $error("address not driven in latch");
  a_read_float: assert property (
    !o_read_strobe_n |-> o_ad_oe[7:0] == 8'h00)
    else $error("lines driven during read");
  a_write_drive: assert property (
    !o_write_strobe_n |-> o_ad_oe[7:0] == 8'hff)
    else $error("write data not driven");
  a_hold_select: assert property (
    $fell(strb) |-> !o_chip_select_n)
    else $error("select dropped with strobe");
  a_window_answer: assert property (
    $rose(i_win_read || i_win_write) |-> s_answer)
    else $error("window request unanswered");
endmodule // mxb_ctrl_monitor
bind mxb_ctrl mxb_ctrl_monitor mon (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_win_read(i_win_read), .i_win_write(i_win_write),
  .o_win_waitrequest(o_win_waitrequest), .o_ad_oe(o_ad_oe),
  .o_chip_select_n(o_chip_select_n), .o_ale(o_ale),
  .o_read_strobe_n(o_read_strobe_n), .o_write_strobe_n(o_write_strobe_n));

// ### mxb_ext_mem.sv
// Model of an 8/16-bit memory behind an address latch.
// Assumes the bench resolves the shared lines and feeds them back.
`timescale 1ns/100ps
module mxb_ext_mem (
  input wire logic i_clk, // System clock
  input wire logic i_w16, // 1 = 16-bit device
  input wire logic [4:0] i_lat, // Read delay in clocks
  input wire logic [15:0] i_ad, // Resolved shared lines
  input wire logic i_cs_n, // Chip select
  input wire logic i_ale, // Latch strobe
  input wire logic i_rd_n, // Read strobe
  input wire logic i_wr_n, // Write strobe
  output logic [15:0] o_ad, // Read data or release pattern
  output logic [15:0] o_addr, // Address seen at a strobe
  output int o_nacc // Strobes seen so far
);
  logic [15:0] mem [0:65535]; // Storage
  logic [15:0] lq; // External latch contents
  logic [15:0] last = 16'h0000; // Last value on the lines
  logic [15:0] a; // Device address inputs
  logic [4:0] age; // Clocks since read strobe fell
  logic sq; // Strobe seen last clock
  logic drv; // Read data on the lines
  initial o_nacc = 0;
  // Upper lines go straight to the device in 8-bit mode
  assign a = i_w16 ? lq : {i_ad[15:8], lq[7:0]};
  assign drv = !i_cs_n && !i_rd_n && age >= i_lat;
  // Released lines toggle so a stale value never passes
  assign o_ad = drv ? mem[a] : ~last;
  // Latch, store and strobe bookkeeping
  always @(posedge i_clk) begin
    if (i_ale) lq <= i_ad;
    if (!i_cs_n && !i_wr_n) mem[a] <= i_ad;
    if (i_rd_n) age <= 5'h00;
    else if (age != 5'h1f) age <= age + 5'h01;
    last <= o_ad;
    sq <= !i_rd_n || !i_wr_n;
    if ((!i_rd_n || !i_wr_n) && !sq) begin
      o_nacc <= o_nacc + 1;
      o_addr <= a;
    end
  end
endmodule // mxb_ext_mem

// ### multiplexed_external_bus_bench.sv
// Self-checking bench for the multiplexed external bus controller.
// Assumes mxb_pkg, mxb_ctrl, its monitor and mxb_ext_mem come first.
`timescale 1ns/100ps
module multiplexed_external_bus_bench;
  logic clk = 1'b0; // System clock
  logic arst_n = 1'b0; // Reset, active low
  logic [3:0] rg_a = 4'h0; // Register address
  logic rg_rd = 1'b0, rg_wr = 1'b0; // Register requests
  logic [16:0] w_a = 17'h0; // Window address
  logic w_rd = 1'b0, w_wr = 1'b0; // Window requests
  logic [31:0] wd = 32'h0; // Write data, both ports
  logic [31:0] rg_q, w_q; // Read data
  logic rg_wq, w_wq; // Stalls
  logic [15:0] ad_o, ad_oe, mem_ad, ad_w, m_addr; // Shared lines
  logic cs_n, ale, rd_n, wr_n; // Controls
  logic m_w16 = 1'b0; // Model width
  logic [4:0] m_lat = 5'h00; // Model read delay
  int m_nacc; // Model strobe count
  int bad_count = 0, n_compared = 0; // Tallies
  int c_ale = 0, c_str = 0, c_hold = 0, c_gap = 0; // Running meters
  int l_ale = 0, l_str = 0, l_hold = 0, l_gap = 0; // Last lengths
  mxb_ctrl dut (.i_clk(clk), .i_arst_n(arst_n), .i_reg_address(rg_a),
    .i_reg_read(rg_rd), .i_reg_write(rg_wr), .i_reg_writedata(wd),
    .i_reg_byteenable(4'hf), .o_reg_readdata(rg_q),
    .o_reg_waitrequest(rg_wq), .i_win_address(w_a), .i_win_read(w_rd),
    .i_win_write(w_wr), .i_win_writedata(wd), .i_win_byteenable(4'hf),
    .o_win_readdata(w_q), .o_win_waitrequest(w_wq), .i_ad(ad_w),
    .o_ad(ad_o), .o_ad_oe(ad_oe), .o_chip_select_n(cs_n), .o_ale(ale),
    .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n));
  mxb_ext_mem ext (.i_clk(clk), .i_w16(m_w16), .i_lat(m_lat),
    .i_ad(ad_w), .i_cs_n(cs_n), .i_ale(ale), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .o_ad(mem_ad), .o_addr(m_addr), .o_nacc(m_nacc));
  // Each line is ours where enabled, else the device's
  assign ad_w = (ad_oe & ad_o) | (~ad_oe & mem_ad);
  always #5 clk = ~clk;
  // Phase lengths measured at the pins
  always @(posedge clk) begin
    c_ale <= ale ? c_ale + 1 : 0;
    c_str <= (!rd_n || !wr_n) ? c_str + 1 : 0;
    c_hold <= (!rd_n || !wr_n || cs_n) ? 0 : c_hold + 1;
    c_gap <= cs_n ? c_gap + 1 : 0;
    if (!ale && c_ale > 0) l_ale <= c_ale;
    if (rd_n && wr_n && c_str > 0) l_str <= c_str;
    if (cs_n && c_hold > 0) l_hold <= c_hold;
    if (!cs_n && c_gap > 0) l_gap <= c_gap;
  end
  function automatic logic [31:0] ctl(bit en, bit w, logic [2:0] dv,
      logic [2:0] al);
    ctl = 32'(en) << mxb_pkg::BIT_ENABLE | 32'(w) << mxb_pkg::BIT_WIDTH16
      | 32'(dv) << mxb_pkg::POS_DIV | 32'(al) << mxb_pkg::POS_LATCH_EXT;
  endfunction
  function automatic logic [31:0] tim(logic [3:0] rr, logic [3:0] wi,
      logic [2:0] h, logic [4:0] ac);
    tim = 32'(rr) << mxb_pkg::POS_RR_IDLE | 32'(wi) << mxb_pkg::POS_W_IDLE
      | 32'(h) << mxb_pkg::POS_HOLD | 32'(ac) << mxb_pkg::POS_ACC;
  endfunction
  task automatic chk_v(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_i(input string nm, input int e, g);
    n_compared++;
    if (g != e) begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // One Avalon transfer on the register or the window port
  task automatic xfer(input bit win, input bit wr, input logic [16:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    w_a <= a;
    rg_a <= a[3:0];
    wd <= d;
    w_rd <= win && !wr;
    w_wr <= win && wr;
    rg_rd <= !win && !wr;
    rg_wr <= !win && wr;
    do begin
      @(posedge clk);
      n++;
    end while ((win ? w_wq : rg_wq) !== 1'b0 && n < 3000);
    q = win ? w_q : rg_q;
    chk_i("answer in time", 1, int'(n < 3000));
    w_rd <= 1'b0;
    w_wr <= 1'b0;
    rg_rd <= 1'b0;
    rg_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("Compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    #200000;
    bad_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    complete_run();
  end
  initial begin
    logic [31:0] q, d;
    logic [16:0] a;
    int i, dv, f, fa, fc, fh, fw, fr, n0;
    bit w16;
    void'($urandom(32'ha7ec4a74));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, writable bits and an unmapped place
    for (i = 0; i < 3; i++) begin
      xfer(0, 0, 17'(4 * i), 32'h0, q);
      chk_v("register reset", 32'h0, q);
      xfer(0, 1, 17'(4 * i), 32'hffff_ffff, q);
      xfer(0, 0, 17'(4 * i), 32'h0, q);
      d = i == 0 ? ctl(1, 1, 7, 7) : i == 1 ? tim(15, 15, 7, 31) : 0;
      chk_v("register bits", d, q);
    end
    // Disabled: answered with no pin activity
    xfer(0, 1, 17'h0, ctl(0, 1, 0, 0), q);
    n0 = m_nacc;
    xfer(1, 0, 17'h1_2344, 32'h0, q);
    chk_v("disabled read", 32'h0, q);
    chk_i("disabled strobes", n0, m_nacc);
    // Widths, dividers and random phase lengths
    for (i = 0; i < 11; i++) begin
      w16 = i > 2;
      dv = w16 ? i - 3 : i;
      f = dv < 6 ? 1 << dv : 1;
      fa = dv == 0 ? $urandom_range(7) : 0;
      fc = dv == 0 ? $urandom_range(31) : 0;
      fh = dv == 0 ? $urandom_range(7) : 0;
      fw = dv == 0 ? $urandom_range(15, 1) : 1;
      fr = dv == 0 ? $urandom_range(15, 1) : 1;
      m_w16 <= w16;
      m_lat <= 5'(fc);
      xfer(0, 1, 17'h4, tim(fr, fw, fh, fc), q);
      xfer(0, 1, 17'h0, ctl(1, w16, 3'(dv), 3'(fa)), q);
      a = {15'($urandom), 2'b00};
      d = $urandom;
      n0 = m_nacc;
      xfer(1, 1, a, d, q);
      chk_i("write parts", w16 ? 2 : 4, m_nacc - n0);
      // Deselect spans one end-of-access clock plus the idle count
      chk_i("write idle", (fw + 1) * f, l_gap);
      xfer(1, 0, w16 ? a : a ^ 17'h1_0000, 32'h0, q);
      chk_v("read data", d, q);
      d = w16 ? 32'({a[16:2], 1'b1}) : 32'({a[15:2], 2'b11});
      chk_v("device address", d, 32'(m_addr));
      chk_i("read idle", (fr + 1) * f, l_gap);
      chk_i("latch width", (fa + 1) * f, l_ale);
      chk_i("access width", (fc + 1) * f, l_str);
      chk_i("hold width", (fh + 1) * f, l_hold);
    end
    complete_run();
  end
endmodule // multiplexed_external_bus_bench
